// >>> shared/clk_ctrl_pkg.sv
package clk_ctrl_pkg;
	// Register byte offsets on the bus
	localparam logic [3:0] CLOCK_CTRL_OFS  = 4'h0;
	localparam logic [3:0] RANGE_TRIM_OFS  = 4'h4;
	localparam logic [3:0] FINE_TRIM_OFS   = 4'h8;
	localparam logic [3:0] STATUS_OFS      = 4'hc;
	// Clock control field positions
	localparam int CPU_SEL_BIT    = 7;
	localparam int EXT_AVAIL_BIT  = 6;
	localparam int EXT_EN_BIT     = 5;
	localparam int BIAS_KEEP_BIT  = 4;
	localparam int XTAL_COLD_BIT  = 3;
	localparam int RC_COLD_BIT    = 2;
	localparam int XTAL_EN_BIT    = 1;
	localparam int RC_EN_BIT      = 0;
	// Trim field positions
	localparam int RANGE_BIT      = 4;
	localparam int RESV_TRIM_BIT  = 5;
	localparam int COARSE_MSB     = 3;
	localparam int FINE_MSB       = 5;
	// Reset values
	localparam logic [7:0] CLOCK_CTRL_RST = 8'h1d;
	localparam logic [5:0] RANGE_TRIM_RST = 6'h00;
	localparam logic [5:0] FINE_TRIM_RST  = 6'h20;
	// Start-up counts
	localparam int XTAL_MASK_CYCLES = 32768;
	localparam int EXT_DETECT_PULSES = 4;
	// Interrupt and event bit positions
	localparam int HIGH_IRQ_FAST_BIT = 6;
	localparam int EVENT_FAST_BIT    = 5;
	localparam int MID_IRQ_SLOW_BIT  = 3;
	localparam int EVENT_SLOW_BIT    = 1;
endpackage : clk_ctrl_pkg

// >>> logic/edge_counter.sv
`timescale 1ns/100ps
// Counts rising edges of a synchronous sample until a target is reached
module edge_counter #(
	parameter int TARGET = 4,
	parameter int W      = 16
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic clear_i,
	input  wire logic run_i,
	input  wire logic sample_i,
	output logic      done_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         last;
		logic         done;
	} st_t;
	st_t s_q;
	st_t s_d;

	// Edge detect and saturating count
	always_comb begin
		s_d = s_q;
		s_d.last = sample_i;
		if (clear_i || !run_i) begin
			s_d.cnt = '0;
			s_d.done = 1'b0;
		end else if (sample_i && !s_q.last && !s_q.done) begin
			if (s_q.cnt == W'(TARGET - 1)) begin
				s_d.done = 1'b1;
			end
			s_d.cnt = s_q.cnt + W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done_o = s_q.done;
endmodule : edge_counter

// >>> logic/rc_xtal_oscillator_control.sv
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
// Overview of operation
// - Reset and leaving sleep enable the RC oscillator and select it for CPU.
// - RC may stop only after crystal start or external select.
// - Clearing RC enable stops RC and its clock; sleep enables it again.
// - Bias-keep holds RC bias active while RC is disabled.
// - Range bit 4 of first trim: 0 low range, 1 tenfold frequency.
// - Coarse trim bits 3:0 scale frequency by value plus one; cold reset zero.
// - Each fine trim increment raises RC frequency by a fixed step.
// - First 32768 crystal cycles are masked from clock propagation.
// - Power-on and sleep clear crystal enable and set crystal cold.
// - Crystal cold clears once 32768 crystal cycles follow enable.
// - Clearing crystal enable or entering sleep stops the crystal.
// - Crystal enable set ignored while external detected or enabled.
// - The 128 Hz tick raises high irq bit 6 and event bit 5.
// - The 1 Hz tick raises mid irq bit 3 and event bit 1.
// - CPU select 0 is RC, 1 crystal or external; sleep clears it.
// - External clock reported available after four input pulses.
module rc_xtal_oscillator_control
	import clk_ctrl_pkg::*;
#(
	parameter int XTAL_MASK = XTAL_MASK_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        sleep_reset_i,
	input  wire logic        xtal_clk_sample_i,
	input  wire logic        ext_clk_sample_i,
	input  wire logic        tick_128_hertz_i,
	input  wire logic        tick_one_hertz_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             rc_osc_enable_o,
	output logic             rc_clock_gate_o,
	output logic             rc_bias_keep_o,
	output logic             rc_range_select_o,
	output logic [3:0]       rc_coarse_trim_o,
	output logic [5:0]       rc_fine_trim_code_o,
	output logic             crystal_enable_o,
	output logic             crystal_clock_gate_o,
	output logic             cpu_clock_select_o,
	output logic             external_clock_enable_o,
	output logic [7:0]       high_priority_irq_flags_o,
	output logic [7:0]       mid_priority_irq_flags_o,
	output logic [7:0]       event_flags_o
);
	typedef struct packed {
		logic        cpu_sel;
		logic        ext_en;
		logic        bias_keep;
		logic        xtal_cold;
		logic        xtal_en;
		logic        xgate;
		logic        rc_en;
		logic [5:0]  range_trim;
		logic [5:0]  fine_trim;
		logic [15:0] xtal_cnt;
		logic        xtal_last;
		logic        fast_last;
		logic        slow_last;
		logic [7:0]  hi_irq;
		logic [7:0]  mid_irq;
		logic [7:0]  evn;
		logic        ack;
		logic [31:0] rdata;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic   ext_avail;
	logic   wr_req;
	logic   rd_req;
	logic   xtal_edge;
	logic   mask_done;
	logic   xtal_blocked;
	logic [7:0] ctrl_view;

	// External clock detector on the clock input
	// four pulse detect
	edge_counter #(
		.TARGET (EXT_DETECT_PULSES),
		.W      (4)
	) ext_detect (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.clear_i  (sleep_reset_i),
		.run_i    (s_q.ext_en),
		.sample_i (ext_clk_sample_i),
		.done_o   (ext_avail)
	);

	// Bus decode, single cycle answer
	assign wr_req = wb_cyc_i && wb_stb_i && !s_q.ack && wb_we_i && wb_sel_i[0];
	assign rd_req = wb_cyc_i && wb_stb_i && !s_q.ack && !wb_we_i;
	assign xtal_edge = xtal_clk_sample_i && !s_q.xtal_last;
	assign mask_done = (s_q.xtal_cnt == 16'(XTAL_MASK - 1)) && xtal_edge;
	assign xtal_blocked = ext_avail || s_q.ext_en;

	// Readback view of clock control
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[CPU_SEL_BIT]   = s_q.cpu_sel;
		ctrl_view[EXT_AVAIL_BIT] = ext_avail;
		ctrl_view[EXT_EN_BIT]    = s_q.ext_en;
		ctrl_view[BIAS_KEEP_BIT] = s_q.bias_keep;
		ctrl_view[XTAL_COLD_BIT] = s_q.xtal_cold;
		ctrl_view[RC_COLD_BIT]   = 1'b0;
		ctrl_view[XTAL_EN_BIT]   = s_q.xtal_en;
		ctrl_view[RC_EN_BIT]     = s_q.rc_en;
	end

	// Next state of all control
	always_comb begin
		s_d = s_q;
		s_d.ack = rd_req || (wb_cyc_i && wb_stb_i && !s_q.ack && wb_we_i);
		s_d.xtal_last = xtal_clk_sample_i;
		s_d.fast_last = tick_128_hertz_i;
		s_d.slow_last = tick_one_hertz_i;
		// Interrupt flags are one-cycle pulses
		s_d.hi_irq = 8'h00;
		s_d.mid_irq = 8'h00;
		s_d.evn = 8'h00;
		if (tick_128_hertz_i && !s_q.fast_last) begin
			s_d.hi_irq[HIGH_IRQ_FAST_BIT] = 1'b1;
			s_d.evn[EVENT_FAST_BIT] = 1'b1;
		end
		if (tick_one_hertz_i && !s_q.slow_last) begin
			s_d.mid_irq[MID_IRQ_SLOW_BIT] = 1'b1;
			s_d.evn[EVENT_SLOW_BIT] = 1'b1;
		end
		if (s_q.xtal_en && s_q.xtal_cold && xtal_edge) begin
			s_d.xtal_cnt = s_q.xtal_cnt + 16'h0001;
		end
		if (s_q.xtal_en && s_q.xtal_cold && mask_done) begin
			s_d.xtal_cold = 1'b0;
		end
		// Register writes
		if (wr_req) begin
			case (wb_adr_i)
				CLOCK_CTRL_OFS: begin
					s_d.cpu_sel = wb_dat_i[CPU_SEL_BIT];
					s_d.ext_en = wb_dat_i[EXT_EN_BIT];
					s_d.bias_keep = wb_dat_i[BIAS_KEEP_BIT];
					if (wb_dat_i[RC_EN_BIT] || s_q.xtal_en || s_q.ext_en) begin
						s_d.rc_en = wb_dat_i[RC_EN_BIT];
					end
					if (!wb_dat_i[XTAL_EN_BIT]) begin
						s_d.xtal_en = 1'b0;
						s_d.xtal_cold = 1'b1;
						s_d.xtal_cnt = 16'h0000;
					end else if (!xtal_blocked && !s_q.xtal_en) begin
						s_d.xtal_en = 1'b1;
						s_d.xtal_cold = 1'b1;
						s_d.xtal_cnt = 16'h0000;
					end
				end
				RANGE_TRIM_OFS: s_d.range_trim = wb_dat_i[5:0];
				FINE_TRIM_OFS: s_d.fine_trim = wb_dat_i[FINE_MSB:0];
				default: ;
			endcase
		end
		// Read data, unmapped reads zero
		s_d.rdata = 32'h0000_0000;
		if (rd_req) begin
			case (wb_adr_i)
				CLOCK_CTRL_OFS: s_d.rdata = {24'h000000, ctrl_view};
				RANGE_TRIM_OFS: s_d.rdata = {26'h0000000, s_q.range_trim};
				FINE_TRIM_OFS:  s_d.rdata = {26'h0000000, s_q.fine_trim};
				STATUS_OFS:     s_d.rdata = {30'h00000000, ext_avail, s_q.xtal_cold};
				default:        s_d.rdata = 32'h0000_0000;
			endcase
		end
		if (sleep_reset_i) begin
			s_d.cpu_sel = 1'b0;
			s_d.rc_en = 1'b1;
			s_d.xtal_en = 1'b0;
			s_d.xtal_cold = 1'b1;
			s_d.xtal_cnt = 16'h0000;
		end
		// crystal clock released only once warm
		s_d.xgate = s_d.xtal_en && !s_d.xtal_cold;
	end

	// State register, cold reset loads documented values
	// fine trim reset value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.cpu_sel <= CLOCK_CTRL_RST[CPU_SEL_BIT];
			s_q.bias_keep <= CLOCK_CTRL_RST[BIAS_KEEP_BIT];
			s_q.xtal_cold <= CLOCK_CTRL_RST[XTAL_COLD_BIT];
			s_q.rc_en <= CLOCK_CTRL_RST[RC_EN_BIT];
			s_q.range_trim <= RANGE_TRIM_RST;
			s_q.fine_trim <= FINE_TRIM_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from state
	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = s_q.rdata;
	assign rc_osc_enable_o = s_q.rc_en;
	assign rc_clock_gate_o = s_q.rc_en;
	assign rc_bias_keep_o = s_q.bias_keep;
	assign rc_range_select_o = s_q.range_trim[RANGE_BIT];
	assign rc_coarse_trim_o = s_q.range_trim[COARSE_MSB:0];
	assign rc_fine_trim_code_o = s_q.fine_trim;
	assign crystal_enable_o = s_q.xtal_en;
	assign crystal_clock_gate_o = s_q.xgate;
	assign cpu_clock_select_o = s_q.cpu_sel;
	assign external_clock_enable_o = s_q.ext_en;
	assign high_priority_irq_flags_o = s_q.hi_irq;
	assign mid_priority_irq_flags_o = s_q.mid_irq;
	assign event_flags_o = s_q.evn;

	// Named steps of a crystal start
	sequence xtal_arm_s;
		wr_req && (wb_adr_i == CLOCK_CTRL_OFS) && wb_dat_i[XTAL_EN_BIT]
			&& !xtal_blocked && !s_q.xtal_en && !sleep_reset_i;
	endsequence
	sequence xtal_cold_s;
		crystal_enable_o && s_q.xtal_cold && !crystal_clock_gate_o;
	endsequence
	sequence xtal_warm_s;
		s_q.xtal_en && s_q.xtal_cold && mask_done && !wr_req && !sleep_reset_i;
	endsequence
	sequence xtal_open_s;
		crystal_enable_o && crystal_clock_gate_o && !s_q.xtal_cold;
	endsequence

	crystal_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(crystal_clock_gate_o) |-> $past(crystal_enable_o) && $past(xtal_edge))
		else $error("crystal clock opened early");
	xtal_arm_a: assert property (@(posedge clk_i) disable iff (rst_i)
		xtal_arm_s |=> xtal_cold_s) else $error("crystal start not cold");
	xtal_warm_a: assert property (@(posedge clk_i) disable iff (rst_i)
		xtal_warm_s |=> xtal_open_s) else $error("crystal stayed cold");
	cold_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(s_q.xtal_cold) |-> $past(s_q.xtal_cnt) == 16'(XTAL_MASK - 1))
		else $error("early cold release");

	sleep_xtal_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sleep_reset_i |=> !crystal_enable_o && s_q.xtal_cold) else $error("sleep kept crystal");
	sleep_rc_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sleep_reset_i |=> rc_osc_enable_o && !cpu_clock_select_o) else $error("sleep no RC");
	reset_rc_a: assert property (@(posedge clk_i)
		$fell(rst_i) |-> rc_osc_enable_o && !cpu_clock_select_o) else $error("reset no RC");

	xtal_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		xtal_blocked && !s_q.xtal_en |=> !s_q.xtal_en) else $error("crystal set while blocked");
	xtal_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_req && (wb_adr_i == CLOCK_CTRL_OFS) && !wb_dat_i[XTAL_EN_BIT]
		|=> !crystal_enable_o && !crystal_clock_gate_o) else $error("crystal not stopped");

	rc_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(s_q.rc_en) |-> $past(s_q.xtal_en) || $past(s_q.ext_en)) else $error("RC stopped early");
	bias_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_req && (wb_adr_i == CLOCK_CTRL_OFS)
		|=> rc_bias_keep_o == 1'($past(wb_dat_i) >> BIAS_KEEP_BIT))
		else $error("bias keep lost");

	range_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_req && (wb_adr_i == RANGE_TRIM_OFS)
		|=> {rc_range_select_o, rc_coarse_trim_o} == 5'($past(wb_dat_i))) else $error("range lost");
	fine_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_req && (wb_adr_i == FINE_TRIM_OFS)
		|=> rc_fine_trim_code_o == 6'($past(wb_dat_i))) else $error("fine trim lost");

	cpu_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_req && (wb_adr_i == CLOCK_CTRL_OFS) && !sleep_reset_i
		|=> cpu_clock_select_o == 1'($past(wb_dat_i) >> CPU_SEL_BIT))
		else $error("cpu select lost");
	ext_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!s_q.ext_en |=> !ext_avail) else $error("external clock without enable");

	fast_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(tick_128_hertz_i)
		|=> high_priority_irq_flags_o[HIGH_IRQ_FAST_BIT] && event_flags_o[EVENT_FAST_BIT])
		else $error("fast tick lost");
	slow_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(tick_one_hertz_i)
		|=> mid_priority_irq_flags_o[MID_IRQ_SLOW_BIT] && event_flags_o[EVENT_SLOW_BIT])
		else $error("slow tick lost");

	pulse_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
		high_priority_irq_flags_o[HIGH_IRQ_FAST_BIT]
		|=> !high_priority_irq_flags_o[HIGH_IRQ_FAST_BIT]) else $error("pulse too long");
	slow_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
		mid_priority_irq_flags_o[MID_IRQ_SLOW_BIT]
		|=> !mid_priority_irq_flags_o[MID_IRQ_SLOW_BIT]) else $error("slow pulse too long");

	trim_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && (wb_adr_i == FINE_TRIM_OFS) |-> wb_dat_o[31:6] == 26'h0) else $error("trim upper set");
	range_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && (wb_adr_i == RANGE_TRIM_OFS) |-> wb_dat_o[31:6] == 26'h0)
		else $error("range upper set");
endmodule : rc_xtal_oscillator_control

// >>> bench/rc_xtal_oscillator_control_test.sv
`timescale 1ns/100ps
module rc_xtal_oscillator_control_test
	import clk_ctrl_pkg::*;
;
	localparam int XM = 8;
	logic        clk_i, rst_i, sleep_reset_i, xtal_s, ext_s, t128, t1;
	logic        cyc, stb, we, ack, rc_en, rc_gate, bias, rng, xen, xgate, cpu, exen;
	logic [3:0]  adr, coarse, sel, bsel;
	logic [5:0]  fine;
	logic [31:0] wdat, rdat;
	logic [7:0]  hi, mi, ev;
	int          error_cnt, compares;
	logic [31:0] rng_state;
	logic [31:0] v, r;

	rc_xtal_oscillator_control #(.XTAL_MASK(XM)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .sleep_reset_i(sleep_reset_i),
		.xtal_clk_sample_i(xtal_s), .ext_clk_sample_i(ext_s),
		.tick_128_hertz_i(t128), .tick_one_hertz_i(t1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.rc_osc_enable_o(rc_en), .rc_clock_gate_o(rc_gate), .rc_bias_keep_o(bias),
		.rc_range_select_o(rng), .rc_coarse_trim_o(coarse), .rc_fine_trim_code_o(fine),
		.crystal_enable_o(xen), .crystal_clock_gate_o(xgate), .cpu_clock_select_o(cpu),
		.external_clock_enable_o(exen), .high_priority_irq_flags_o(hi),
		.mid_priority_irq_flags_o(mi), .event_flags_o(ev));

	// Clock generation
	always #4 clk_i = ~clk_i;

	function automatic logic [31:0] rnd();
		rng_state ^= rng_state << 13;
		rng_state ^= rng_state >> 17;
		rng_state ^= rng_state << 5;
		return rng_state;
	endfunction : rnd

	task automatic stop_test();
		if (error_cnt == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One classic cycle; held until ack is sampled high at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= bsel;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
			if (n > 50) begin
				error_cnt++;
				stop_test();
			end
		end while (ack !== 1'b1);
		// Read data taken at the edge that sees ack
		v = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(negedge clk_i);
	endtask : bus

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(v, exp);
	endtask : rd

	task automatic edges(input int ext, input int n);
		repeat (n) begin
			@(posedge clk_i);
			if (ext) ext_s <= 1'b1; else xtal_s <= 1'b1;
			@(posedge clk_i);
			if (ext) ext_s <= 1'b0; else xtal_s <= 1'b0;
		end
		repeat (3) @(negedge clk_i);
	endtask : edges

	// Tick held a random time must give exactly one flagged cycle
	task automatic tick_chk(input int slow);
		int hold, hits;
		logic [23:0] got;
		hold = 1 + int'(rnd() % 4);
		hits = 0;
		got = 24'h0;
		@(posedge clk_i);
		if (slow) t1 <= 1'b1; else t128 <= 1'b1;
		for (int i = 0; i < hold + 4; i++) begin
			@(posedge clk_i);
			if (i == hold) begin
				t1 <= 1'b0;
				t128 <= 1'b0;
			end
			@(negedge clk_i);
			if ({hi, mi, ev} !== 24'h0) begin
				hits++;
				got = {hi, mi, ev};
			end
		end
		chk(32'(hits), 32'h1);
		if (slow) chk({8'h0, got}, {16'h0, 8'h1 << MID_IRQ_SLOW_BIT, 8'h1 << EVENT_SLOW_BIT});
		else chk({8'h0, got}, {8'h1 << HIGH_IRQ_FAST_BIT, 8'h0, 8'h1 << EVENT_FAST_BIT});
	endtask : tick_chk

	// Main sequence
	initial begin
		clk_i = 1'h0;
		rst_i = 1'h1;
		sleep_reset_i = 1'h0;
		xtal_s = 1'h0;
		ext_s = 1'h0;
		t128 = 1'h0;
		t1 = 1'h0;
		cyc = 1'h0;
		stb = 1'h0;
		we = 1'h0;
		adr = 4'h0;
		sel = 4'hf;
		bsel = 4'hf;
		wdat = 32'h0;
		r = 32'h0;
		error_cnt = 0;
		compares = 0;
		rng_state = 32'h0001_29d1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		// RC cold bit reads zero, no RC start model
		rd(CLOCK_CTRL_OFS, {24'h0, CLOCK_CTRL_RST & ~(8'h01 << RC_COLD_BIT)});
		rd(RANGE_TRIM_OFS, 32'h0);
		rd(FINE_TRIM_OFS, 32'h20);
		rd(STATUS_OFS, 32'h1);
		chk({rc_en, rc_gate, cpu, xen, bias}, 5'b11001);
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			bus(1'b1, RANGE_TRIM_OFS, r);
			rd(RANGE_TRIM_OFS, r & 32'h3f);
			chk({rng, coarse}, r[4:0]);
			r = rnd();
			bus(1'b1, FINE_TRIM_OFS, r);
			rd(FINE_TRIM_OFS, r & 32'h3f);
			chk(fine, r[5:0]);
		end
		// Write with byte lane zero off is dropped
		bsel = 4'he;
		bus(1'b1, FINE_TRIM_OFS, ~r);
		bsel = 4'hf;
		rd(FINE_TRIM_OFS, r & 32'h3f);
		rd(4'h2, 32'h0);
		bus(1'b1, CLOCK_CTRL_OFS, 32'h10);
		chk(rc_en, 1'b1);
		bus(1'b1, CLOCK_CTRL_OFS, 32'h93);
		chk({cpu, xen, xgate}, 3'b110);
		edges(0, XM - 1);
		rd(STATUS_OFS, 32'h1);
		edges(0, 1);
		rd(STATUS_OFS, 32'h0);
		chk(xgate, 1'b1);
		bus(1'b1, CLOCK_CTRL_OFS, 32'h92);
		chk({rc_en, rc_gate, bias}, 3'b001);
		bus(1'b1, CLOCK_CTRL_OFS, 32'h82);
		chk(bias, 1'b0);
		@(posedge clk_i) sleep_reset_i <= 1'b1;
		@(posedge clk_i) sleep_reset_i <= 1'b0;
		@(negedge clk_i);
		chk({rc_en, cpu, xen, fine}, {3'b100, r[5:0]});
		rd(STATUS_OFS, 32'h1);
		bus(1'b1, CLOCK_CTRL_OFS, 32'h83);
		bus(1'b1, CLOCK_CTRL_OFS, 32'h81);
		chk({xen, xgate}, 2'b00);
		bus(1'b1, CLOCK_CTRL_OFS, 32'h21);
		bus(1'b1, CLOCK_CTRL_OFS, 32'h23);
		chk({exen, xen}, 2'b10);
		edges(1, EXT_DETECT_PULSES - 1);
		rd(STATUS_OFS, 32'h1);
		edges(1, 1);
		rd(STATUS_OFS, 32'h3);
		bus(1'b1, CLOCK_CTRL_OFS, 32'h03);
		chk(xen, 1'b0);
		for (int i = 0; i < 6; i++) tick_chk(i % 2);
		stop_test();
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		stop_test();
	end
endmodule : rc_xtal_oscillator_control_test
